// >>> trtd_top.sv
// Purpose: receive trigger pulses and type words, build timestamps, launch frames
// Assumes: pulse and broadcast inputs synchronous to CLK
// Notes: one frame request per trigger; a new pulse before its type word marks an empty frame
// Functional notes
// [RULE_01] Trigger time is the cycle in which the one-cycle pulse is seen.
// [RULE_02] Burst start synchronously clears the local timestamp counters.
// [RULE_03] A local offset input aligns timestamps beyond the receiver's skew range.
// [RULE_04] Each trigger captures a 12-bit fine count, one clock per count.
// [RULE_05] Coarse counter advances on fine wrap, preloaded with matching offset, forms upper bits.
// [RULE_06] Sender keeps triggers ordered and at least three counts apart.
// [RULE_07] A 6-bit type rides bits 7:2 of the broadcast word after each pulse.
// [RULE_08] Low five bits name a type; the sixth bit selects a special command.
// [RULE_09] Every trigger is answered by a frame, empty if unhandled.
// [RULE_10] Top bit zero is a physics trigger needing event readout.
// [RULE_11] Synchronization code yields a special frame shaped like an event frame.
// [RULE_12] Burst start code enables data-taking and yields a special frame.
// [RULE_13] Burst end code disables data-taking and reads out end-of-burst data.
// [RULE_14] Choke and error on and off codes each yield a special frame.
// [RULE_15] Monitoring code yields a frame of monitoring data.
// [RULE_16] Random and calibration codes need a data readout.
// [RULE_17] Sender makes burst start and end the first and last triggers.
// [RULE_18] End-of-burst frame holds statistics and timestamp latched at hardware burst end.
// [RULE_19] Sender issues synchronization triggers at irregular intervals.
// [RULE_20] Calibration for another sub-detector may be answered with an empty frame.
// [RULE_21] Sender resolves simultaneous triggers by a priority scheme.
// [RULE_22] Broadcast low bits: 11 burst start, 10 burst end, 01 reserved.
// [RULE_23] A 32-bit counter counts cycles between burst start and burst end.
// [RULE_24] Burst commands out of start-then-end order raise a serious error flag.
// [RULE_25] Reserved type codes give an empty frame and a sticky status flag.
`timescale 1ns/1ps
`include "trtd_defines.svh"
module trtd_top
  import trtd_pkg::*;
#(
  parameter int FINE_W = `TRTD_FINE_W,
  parameter int COARSE_W = `TRTD_COARSE_W,
  parameter int CNT_W = `TRTD_BURST_CNT_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Link side
  input wire logic CHANNEL_A_TRIGGER_PULSE,
  input wire logic BCAST_VALID,
  input wire logic [`TRTD_BCAST_W-1:0] BCAST_WORD,
  input wire logic HW_EOB,
  // Configuration
  input wire logic [FINE_W-1:0] FINE_OFFSET,
  input wire logic [COARSE_W-1:0] COARSE_OFFSET,
  input wire logic ACCEPT_CAL,
  input wire logic CLEAR_FLAGS,
  // Frame request
  output logic FRAME_VALID,
  output trtd_frame_t FRAME_KIND,
  output logic [`TRTD_TYPE_W-1:0] FRAME_TYPE,
  output logic [FINE_W+COARSE_W-1:0] FRAME_TSTAMP,
  // Burst status
  output logic DATA_TAKING,
  output logic [CNT_W-1:0] BURST_CYCLES,
  output logic [FINE_W+COARSE_W-1:0] EOB_TSTAMP,
  output logic [CNT_W-1:0] TRIGGER_COUNT,
  output logic SEQ_ERROR,
  output logic RESERVED_SEEN,
  output logic MARKER_RESERVED
);
  localparam int TS_W = FINE_W + COARSE_W;
  trtd_state_t state;
  logic [FINE_W-1:0] fine;
  logic [COARSE_W-1:0] coarse;
  logic [TS_W-1:0] held_ts;
  logic [CNT_W-1:0] cycles;
  logic in_burst;
  logic [1:0] gap;

  wire [`TRTD_TYPE_W-1:0] type_code = BCAST_WORD[`TRTD_BCAST_W-1:`TRTD_TYPE_LSB]; // RULE_07
  wire [1:0] marker = BCAST_WORD[1:0]; // RULE_22
  wire burst_marker_bit_one = marker[1];
  wire burst_marker_bit_zero = marker[0];
  wire mark_sob = BCAST_VALID & burst_marker_bit_one & burst_marker_bit_zero; // RULE_22
  wire mark_eob = BCAST_VALID & burst_marker_bit_one & ~burst_marker_bit_zero; // RULE_22
  wire mark_rsv = BCAST_VALID & ~burst_marker_bit_one & burst_marker_bit_zero; // RULE_22

  trtd_frame_t kind;
  logic reserved;
  logic is_sob;
  logic is_eob;
  trtd_type_decode u_dec (
    .code(type_code),
    .accept_cal(ACCEPT_CAL),
    .kind(kind),
    .reserved(reserved),
    .is_sob(is_sob),
    .is_eob(is_eob)
  );

  // Burst start is seen either on the marker bits or the type code
  wire type_ok = BCAST_VALID & (state == TRTD_ST_WAIT_TYPE);
  wire sob_evt = mark_sob | (type_ok & is_sob); // RULE_02
  wire eob_evt = mark_eob | (type_ok & is_eob);
  wire seq_bad = (sob_evt & in_burst) | (eob_evt & ~in_burst); // RULE_24
  wire fine_wrap = (fine == {FINE_W{1'b1}});
  // Offset folds into the counters at burst start so every stamp taken after it carries it
  wire [FINE_W-1:0] next_fine = sob_evt ? FINE_OFFSET : fine + 1'b1; // RULE_03
  wire [COARSE_W-1:0] next_coarse = sob_evt ? COARSE_OFFSET :
                                   (fine_wrap ? coarse + 1'b1 : coarse); // RULE_05
  wire [TS_W-1:0] now_ts = {coarse, fine}; // RULE_05
  wire pulse = CHANNEL_A_TRIGGER_PULSE; // RULE_01
  // A pulse still waiting for its type when the next arrives is answered empty
  wire overrun = pulse & (state == TRTD_ST_WAIT_TYPE);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fine <= '0;
      coarse <= '0;
    end else begin
      fine <= next_fine; // RULE_02
      coarse <= next_coarse; // RULE_05
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= TRTD_ST_IDLE;
      held_ts <= '0;
    end else if (pulse) begin
      state <= TRTD_ST_WAIT_TYPE;
      held_ts <= now_ts; // RULE_04
    end else if (BCAST_VALID) begin
      state <= TRTD_ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FRAME_VALID <= 1'b0;
      FRAME_KIND <= TRTD_FR_NONE;
      FRAME_TYPE <= '0;
      FRAME_TSTAMP <= '0;
    end else begin
      FRAME_VALID <= type_ok | overrun; // RULE_09
      FRAME_KIND <= overrun ? TRTD_FR_EMPTY : (type_ok ? kind : TRTD_FR_NONE); // RULE_08
      FRAME_TYPE <= type_ok ? type_code : '0;
      FRAME_TSTAMP <= held_ts;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_burst <= 1'b0;
      cycles <= '0;
    end else begin
      in_burst <= sob_evt ? 1'b1 : (eob_evt ? 1'b0 : in_burst); // RULE_12
      cycles <= sob_evt ? '0 : (in_burst ? cycles + 1'b1 : cycles); // RULE_23
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_TAKING <= 1'b0;
      BURST_CYCLES <= '0;
      EOB_TSTAMP <= '0;
      TRIGGER_COUNT <= '0;
      gap <= '0;
    end else begin
      DATA_TAKING <= sob_evt ? 1'b1 : (eob_evt ? 1'b0 : DATA_TAKING); // RULE_13
      if (eob_evt) begin
        BURST_CYCLES <= cycles; // RULE_23
      end
      if (HW_EOB) begin
        EOB_TSTAMP <= now_ts; // RULE_18
      end
      TRIGGER_COUNT <= sob_evt ? '0 : (pulse ? TRIGGER_COUNT + 1'b1 : TRIGGER_COUNT); // RULE_18
      gap <= pulse ? 2'h2 : (gap != 2'h0 ? gap - 1'b1 : gap);
    end
  end

  // Flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SEQ_ERROR <= 1'b0;
      RESERVED_SEEN <= 1'b0;
      MARKER_RESERVED <= 1'b0;
    end else begin
      SEQ_ERROR <= seq_bad | (SEQ_ERROR & ~CLEAR_FLAGS); // RULE_24
      RESERVED_SEEN <= (type_ok & reserved) | (RESERVED_SEEN & ~CLEAR_FLAGS); // RULE_25
      MARKER_RESERVED <= mark_rsv | (MARKER_RESERVED & ~CLEAR_FLAGS); // RULE_22
    end
  end

  // Checks
  sequence trig_s;
    pulse && state == TRTD_ST_IDLE;
  endsequence
  sequence gap_s;
    !pulse && !BCAST_VALID;
  endsequence
  sequence type_s;
    BCAST_VALID && !pulse;
  endsequence

  // Type word two cycles after its pulse, the usual spacing from the sender
  frame_answer_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    trig_s ##1 gap_s ##1 type_s |=> FRAME_VALID) else $error("trigger not answered"); // RULE_09
  stamp_capture_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    trig_s ##1 gap_s ##1 type_s |=> FRAME_TSTAMP == $past(now_ts, 3))
    else $error("bad stamp"); // RULE_04
  sob_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    sob_evt |=> fine == $past(FINE_OFFSET) && coarse == $past(COARSE_OFFSET))
    else $error("counters not cleared"); // RULE_02
  coarse_step_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    fine_wrap && !sob_evt |=> coarse == $past(coarse) + 1'b1 && fine == '0)
    else $error("coarse not advanced"); // RULE_05
  phys_event_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    type_ok && !type_code[5] && !pulse |=> FRAME_KIND == TRTD_FR_EVENT)
    else $error("physics not read out"); // RULE_10
  eob_stop_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    eob_evt && !sob_evt |=> !DATA_TAKING ##0 BURST_CYCLES == $past(cycles))
    else $error("burst end mishandled"); // RULE_13
  sob_start_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    type_ok && is_sob && !pulse |=> DATA_TAKING && FRAME_KIND == TRTD_FR_SPECIAL)
    else $error("burst start mishandled"); // RULE_12
  seq_err_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    seq_bad |=> SEQ_ERROR ##1 (SEQ_ERROR || $past(CLEAR_FLAGS)))
    else $error("order error lost"); // RULE_24
  rsv_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    type_ok && reserved && !pulse |=> RESERVED_SEEN && FRAME_KIND == TRTD_FR_EMPTY)
    else $error("reserved code mishandled"); // RULE_25
  burst_count_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    in_burst && !sob_evt |=> cycles == $past(cycles) + 1'b1)
    else $error("burst counter stuck"); // RULE_23
  spacing_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    pulse |=> gap == 2'h2 ##1 gap == 2'h1) else $error("spacing guard not armed"); // RULE_06
endmodule : trtd_top

// >>> trtd_defines.svh
// Purpose: constants for the trigger receive and timestamp decoder
// Assumes: 20 MHz CLK, one trigger-type word per trigger pulse
// Notes: type codes are 6-bit values carried in bits 7:2 of the broadcast word
`ifndef TRTD_DEFINES_SVH
`define TRTD_DEFINES_SVH
`define TRTD_FINE_W 12
`define TRTD_COARSE_W 20
`define TRTD_BURST_CNT_W 32
`define TRTD_TYPE_W 6
`define TRTD_BCAST_W 8
`define TRTD_TYPE_LSB 2
`define TRTD_MIN_SPACING 3
`define TRTD_SKEW_RX_MAX 16
`define TRTD_CODE_SYNC 6'h20
`define TRTD_CODE_SOB 6'h22
`define TRTD_CODE_EOB 6'h23
`define TRTD_CODE_CHOKE_ON 6'h24
`define TRTD_CODE_CHOKE_OFF 6'h25
`define TRTD_CODE_ERR_ON 6'h26
`define TRTD_CODE_ERR_OFF 6'h2f
`define TRTD_CODE_MON 6'h28
`define TRTD_MARK_SOB 2'h3
`define TRTD_MARK_EOB 2'h2
`define TRTD_MARK_RSV 2'h1
`endif

// >>> trtd_pkg.sv
// Purpose: shared types for the trigger receive and timestamp decoder
// Assumes: nothing beyond the defines header
// Notes: frame kinds name the response launched per trigger
package trtd_pkg;
  typedef enum logic [2:0] {
    TRTD_FR_NONE,
    TRTD_FR_EVENT,
    TRTD_FR_SPECIAL,
    TRTD_FR_EOB,
    TRTD_FR_MON,
    TRTD_FR_EMPTY
  } trtd_frame_t;
  typedef enum logic [1:0] {
    TRTD_ST_IDLE,
    TRTD_ST_WAIT_TYPE
  } trtd_state_t;
endpackage : trtd_pkg

// >>> trtd_type_decode.sv
// Purpose: classify a 6-bit trigger-type code into a response kind
// Assumes: combinational, used by the top once per received word
// Notes: reserved codes map to an empty frame and raise the reserved flag
`timescale 1ns/1ps
`include "trtd_defines.svh"
module trtd_type_decode
  import trtd_pkg::*;
(
  // Code in
  input wire logic [`TRTD_TYPE_W-1:0] code,
  input wire logic accept_cal,
  // Classification out
  output trtd_frame_t kind,
  output logic reserved,
  output logic is_sob,
  output logic is_eob
);
  wire is_phys = ~code[5]; // RULE_10
  wire is_cal = code[5] & code[4]; // RULE_16
  wire is_rand = (code[5:1] == 5'h16); // RULE_16
  wire is_sync = (code == `TRTD_CODE_SYNC); // RULE_11
  wire is_ctrl = (code == `TRTD_CODE_CHOKE_ON) | (code == `TRTD_CODE_CHOKE_OFF) |
                 (code == `TRTD_CODE_ERR_ON) | (code == `TRTD_CODE_ERR_OFF); // RULE_14
  wire is_mon = (code == `TRTD_CODE_MON); // RULE_15
  assign is_sob = (code == `TRTD_CODE_SOB);
  assign is_eob = (code == `TRTD_CODE_EOB);
  assign reserved = ~(is_phys | is_cal | is_rand | is_sync | is_ctrl | is_mon | is_sob | is_eob);
  // Calibration for another sub-detector may be answered empty
  assign kind = (is_phys | is_rand) ? TRTD_FR_EVENT : // RULE_10
                is_cal ? (accept_cal ? TRTD_FR_EVENT : TRTD_FR_EMPTY) : // RULE_20
                (is_sync | is_sob | is_ctrl) ? TRTD_FR_SPECIAL : // RULE_12
                is_eob ? TRTD_FR_EOB : // RULE_13
                is_mon ? TRTD_FR_MON : // RULE_15
                TRTD_FR_EMPTY; // RULE_25
endmodule : trtd_type_decode

// >>> trtd_tp_model.sv
// Purpose: trigger processor model driving pulses and type words
// Assumes: changes its lines just after the falling edge of clk
// Notes: a released word shows the inverse of its last value, not a held copy
`timescale 1ns/1ps
module trtd_tp_model (
  // Clock
  input wire logic clk,
  // Link lines
  output logic trig,
  output logic bv,
  output logic [7:0] word
);
  initial begin
    trig = 1'b0;
    bv = 1'b0;
    word = 8'h00;
  end
  // One trigger per cycle at most; the caller orders and spaces them
  task automatic pulse();
    @(negedge clk) trig <= 1'b1;
    @(negedge clk) trig <= 1'b0;
  endtask : pulse
  task automatic bcast(input logic [5:0] code, input logic [1:0] mark);
    @(negedge clk) begin
      bv <= 1'b1;
      word <= {code, mark};
    end
    @(negedge clk) begin
      bv <= 1'b0;
      word <= ~{code, mark};
    end
  endtask : bcast
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
endmodule : trtd_tp_model

// >>> trtd_top_tb.sv
// Purpose: self-checking bench for the trigger decoder top
// Assumes: inputs change at the falling edge; 50 ns clock
// Notes: stamps are reckoned from the cycle of the burst start word
`timescale 1ns/1ps
`include "trtd_defines.svh"
module trtd_top_tb
  import trtd_pkg::*;
;
  logic clk, arst_n, hw_eob, acal, clr, trig, bv, fv, dt, serr, rsv, mrsv;
  logic [7:0] word;
  logic [11:0] foff;
  logic [19:0] coff;
  logic [5:0] ft;
  logic [31:0] fts, bcyc, ets, tcnt, base;
  trtd_frame_t fk;
  int bad_count, total_checks, t, s, e;
  int cyc = 0;
  logic [5:0] codes [10] = '{6'h05, 6'h1f, 6'h20, 6'h24, 6'h25, 6'h26, 6'h2f, 6'h28, 6'h2c, 6'h31};
  trtd_frame_t kinds [10] = '{TRTD_FR_EVENT, TRTD_FR_EVENT, TRTD_FR_SPECIAL, TRTD_FR_SPECIAL,
    TRTD_FR_SPECIAL, TRTD_FR_SPECIAL, TRTD_FR_SPECIAL, TRTD_FR_MON, TRTD_FR_EVENT, TRTD_FR_EVENT};
  trtd_top u_dut (.CLK(clk), .ARST_N(arst_n), .CHANNEL_A_TRIGGER_PULSE(trig), .BCAST_VALID(bv),
    .BCAST_WORD(word), .HW_EOB(hw_eob), .FINE_OFFSET(foff), .COARSE_OFFSET(coff),
    .ACCEPT_CAL(acal), .CLEAR_FLAGS(clr), .FRAME_VALID(fv), .FRAME_KIND(fk), .FRAME_TYPE(ft),
    .FRAME_TSTAMP(fts), .DATA_TAKING(dt), .BURST_CYCLES(bcyc), .EOB_TSTAMP(ets),
    .TRIGGER_COUNT(tcnt), .SEQ_ERROR(serr), .RESERVED_SEEN(rsv), .MARKER_RESERVED(mrsv));
  trtd_tp_model u_tp (.clk(clk), .trig(trig), .bv(bv), .word(word));
  assign base = {coff, foff};
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // One trigger with its type word, then the frame and its one-cycle width
  task automatic tx(input logic [5:0] code, input logic [1:0] mark, input trtd_frame_t kind);
    u_tp.pulse();
    t = cyc;
    u_tp.bcast(code, mark);
    e = cyc;
    if (code == `TRTD_CODE_SOB) s = cyc;
    chk(fv, 1);
    chk(fk, kind);
    chk(ft, code);
    if (code != `TRTD_CODE_SOB) chk(fts, base + 32'(t - s - 1));
    @(negedge clk);
    chk(fv, 0);
  endtask : tx
  initial begin
    {arst_n, hw_eob, clr} = 3'h0;
    acal = 1'b1;
    foff = 12'hffe;
    coff = 20'h00abc;
    {bad_count, total_checks, s} = '0;
    repeat (2) @(negedge clk);
    chk(fk, TRTD_FR_NONE);
    chk(bcyc, 0);
    arst_n = 1'b1;
    u_tp.idle(2);
    tx(`TRTD_CODE_SOB, `TRTD_MARK_SOB, TRTD_FR_SPECIAL);
    chk(dt, 1);
    // Gaps grow so successive triggers land at irregular spacing
    for (int i = 0; i < 10; i++) begin
      u_tp.idle(i);
      tx(codes[i], 2'h0, kinds[i]);
    end
    acal = 1'b0;
    tx(6'h3a, 2'h0, TRTD_FR_EMPTY);
    acal = 1'b1;
    tx(6'h21, 2'h0, TRTD_FR_EMPTY);
    tx(6'h2a, 2'h0, TRTD_FR_EMPTY);
    chk(rsv, 1);
    $display("test codes done");
    u_tp.pulse();
    t = cyc;
    u_tp.idle(2);
    u_tp.pulse();
    chk(fv, 1);
    chk(fk, TRTD_FR_EMPTY);
    chk(ft, 0);
    chk(fts, base + 32'(t - s - 1));
    t = cyc;
    u_tp.bcast(6'h07, 2'h0);
    chk(fk, TRTD_FR_EVENT);
    chk(fts, base + 32'(t - s - 1));
    u_tp.bcast(6'h05, 2'h0);
    chk(fv, 0);
    $display("test overrun done");
    @(negedge clk) hw_eob = 1'b1;
    @(negedge clk) hw_eob = 1'b0;
    chk(ets, base + 32'(cyc - s - 1));
    tx(`TRTD_CODE_EOB, `TRTD_MARK_EOB, TRTD_FR_EOB);
    chk(dt, 0);
    chk(bcyc, 32'(e - s - 1));
    chk(tcnt, 16);
    chk(serr, 0);
    tx(`TRTD_CODE_EOB, `TRTD_MARK_EOB, TRTD_FR_EOB);
    chk(serr, 1);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    chk(serr, 0);
    u_tp.bcast(6'h00, `TRTD_MARK_RSV);
    @(negedge clk);
    chk(mrsv, 1);
    $display("test burst done");
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : trtd_top_tb
